//--- hdl/encoder_feedback_map.svh
// How it works
// - A pulses-per-revolution setting from 0 to 60000 is held, starting at 1000.
// - Writes to resolution, polarity and divider settings are refused while the motor runs.
// - With polarity 0, phase A leading means forward and phase B leading means reverse.
// - With polarity 1, phase B leading means forward and phase A leading means reverse.
// - The rotation sense comes from which phase leads, flipped by a one-bit polarity.
// - The encoder pulse train is divided onto the pulse monitor output.
// - The divider code holds n (0 or 1) and m (1 to 32), legal 1-32 and 101-132, default 1.
// - Monitor pulses come at the input rate times (1 + n) over m.
// - The effective division ratio is held between 1/32 and 1.
`ifndef ENCODER_FEEDBACK_MAP_SVH
`define ENCODER_FEEDBACK_MAP_SVH

`define IDX_PPR 3'h0
`define IDX_POL 3'h1
`define IDX_DIV 3'h2
`define IDX_STATUS 3'h3
`define IDX_POS 3'h4

`define PPR_RESET 16'h03e8
`define PPR_MAX 32'h0000ea60
`define DIV_RESET 8'h01
`define DIV_M_MIN 32'h00000001
`define DIV_M_MAX 32'h00000020
`define DIV_N1_MIN 32'h00000065
`define DIV_N1_MAX 32'h00000084
`define DIV_N1_BASE 8'h64

`define STAT_RUN_BIT 0
`define STAT_FWD_BIT 1
`define STAT_REJ_BIT 2

`endif

//--- hdl/encoder_feedback_pkg.sv
package encoder_feedback_pkg;
  typedef enum logic [1:0] {
    resp_okay = 2'b00,
    resp_slverr = 2'b10
  } resp_type;
endpackage

//--- hdl/encoder_feedback_interface.sv
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "encoder_feedback_map.svh"
module encoder_feedback_interface (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic phase_z_i,
  input wire logic motor_running_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic pulse_monitor_o,
  output logic forward_o
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic div_legal(input logic [31:0] v);
    return ((v >= `DIV_M_MIN) && (v <= `DIV_M_MAX)) ||
           ((v >= `DIV_N1_MIN) && (v <= `DIV_N1_MAX));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Encoder input synchronisers, bit 0 = A, 1 = B, 2 = Z

  logic [2:0] in_meta_reg;
  logic [2:0] in_sync_reg;
  logic [2:0] in_prev_reg;
  always_ff @(posedge clk_i) begin
    in_meta_reg <= sys_rst_i ? 3'h0 : {phase_z_i, phase_b_i, phase_a_i};
    in_sync_reg <= sys_rst_i ? 3'h0 : in_meta_reg;
    in_prev_reg <= sys_rst_i ? 3'h0 : in_sync_reg;
  end
  wire logic a_rise = in_sync_reg[0] & ~in_prev_reg[0];
  wire logic z_rise = in_sync_reg[2] & ~in_prev_reg[2];
  wire logic b_level = in_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [15:0] ppr_reg;
  logic pol_reg;
  logic [7:0] div_code_reg;
  logic reject_reg;
  logic [15:0] pos_reg;
  logic [6:0] acc_reg;
  logic forward_reg;
  logic monitor_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [2:0] aw_idx_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  wire logic aw_take = s_axi_awvalid_i & awready_reg;
  wire logic w_take = s_axi_wvalid_i & wready_reg;
  wire logic do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire logic aw_got_next = (aw_got_reg & ~do_write) | aw_take;
  wire logic w_got_next = (w_got_reg & ~do_write) | w_take;
  wire logic bvalid_next = do_write | (bvalid_reg & ~s_axi_bready_i);
  wire logic ar_take = s_axi_arvalid_i & arready_reg;
  wire logic rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready_i);
  wire logic [2:0] ar_idx = s_axi_araddr_i[4:2];
  wire logic ar_mapped = (s_axi_araddr_i[31:5] == 27'h0) && (ar_idx <= `IDX_POS);

  // Settings may only change with the motor stopped
  wire logic unlocked = ~motor_running_i;
  wire logic [31:0] ppr_val = merge({16'h0, ppr_reg}, w_data_reg, w_strb_reg);
  wire logic [31:0] pol_val = merge({31'h0, pol_reg}, w_data_reg, w_strb_reg);
  wire logic [31:0] div_val = merge({24'h0, div_code_reg}, w_data_reg, w_strb_reg);
  wire logic wr_ppr = do_write & (aw_idx_reg == `IDX_PPR) & unlocked &
                      (ppr_val <= `PPR_MAX);
  wire logic wr_pol = do_write & (aw_idx_reg == `IDX_POL) & unlocked & (pol_val[31:1] == 31'h0);
  wire logic wr_div = do_write & (aw_idx_reg == `IDX_DIV) & unlocked & div_legal(div_val);
  wire logic wr_ok = wr_ppr | wr_pol | wr_div;

  wire logic [31:0] status_word = {29'h0, reject_reg, forward_reg, motor_running_i};
  wire logic [31:0] rd_word = (ar_idx == `IDX_PPR) ? {16'h0, ppr_reg} :
                              (ar_idx == `IDX_POL) ? {31'h0, pol_reg} :
                              (ar_idx == `IDX_DIV) ? {24'h0, div_code_reg} :
                              (ar_idx == `IDX_STATUS) ? status_word :
                              (ar_idx == `IDX_POS) ? {16'h0, pos_reg} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awready_reg <= ~aw_got_next;
      wready_reg <= ~w_got_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_idx_reg <= 3'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bresp_reg <= encoder_feedback_pkg::resp_okay;
      rresp_reg <= encoder_feedback_pkg::resp_okay;
      rdata_reg <= 32'h0;
    end else begin
      if (aw_take) begin
        aw_idx_reg <= (s_axi_awaddr_i[31:5] == 27'h0) ? s_axi_awaddr_i[4:2] : 3'h7;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (do_write) begin
        bresp_reg <= wr_ok ? encoder_feedback_pkg::resp_okay : encoder_feedback_pkg::resp_slverr;
      end
      if (ar_take) begin
        rdata_reg <= ar_mapped ? rd_word : 32'h0;
        rresp_reg <= ar_mapped ? encoder_feedback_pkg::resp_okay :
                                 encoder_feedback_pkg::resp_slverr;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ppr_reg <= `PPR_RESET;
      pol_reg <= 1'b0;
      div_code_reg <= `DIV_RESET;
      reject_reg <= 1'b0;
    end else begin
      if (wr_ppr) begin
        ppr_reg <= ppr_val[15:0];
      end
      if (wr_pol) begin
        pol_reg <= pol_val[0];
      end
      if (wr_div) begin
        div_code_reg <= div_val[7:0];
      end
      if (do_write) begin
        reject_reg <= ~wr_ok;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction, position and monitor divider

  // A rising while B is low means A leads; polarity flips the sense
  wire logic fwd_now = ~b_level ^ pol_reg;
  wire logic div_n = div_code_reg >= `DIV_N1_BASE;
  wire logic [6:0] div_m = div_n ? 7'(div_code_reg - `DIV_N1_BASE) : div_code_reg[6:0];
  wire logic [6:0] div_inc = div_n ? 7'h2 : 7'h1;
  // A code of 101 would give 2/1; the ratio is capped at one
  wire logic [6:0] eff_inc = (div_inc > div_m) ? div_m : div_inc;
  wire logic [6:0] acc_sum = acc_reg + eff_inc;
  wire logic acc_hit = acc_sum >= div_m;
  wire logic [15:0] ppr_last = ppr_reg - 16'h1;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_reg <= 7'h0;
      monitor_reg <= 1'b0;
      forward_reg <= 1'b1;
      pos_reg <= 16'h0;
    end else begin
      monitor_reg <= a_rise & acc_hit;
      if (wr_div) begin
        acc_reg <= 7'h0;
      end else if (a_rise) begin
        acc_reg <= acc_hit ? 7'(acc_sum - div_m) : acc_sum;
      end
      if (a_rise) begin
        forward_reg <= fwd_now;
      end
      // Index resets position; a zero resolution parks it at zero
      if (z_rise || ppr_reg == 16'h0) begin
        pos_reg <= 16'h0;
      end else if (a_rise && fwd_now) begin
        pos_reg <= (pos_reg >= ppr_last) ? 16'h0 : pos_reg + 16'h1;
      end else if (a_rise) begin
        pos_reg <= (pos_reg == 16'h0) ? ppr_last : pos_reg - 16'h1;
      end
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign pulse_monitor_o = monitor_reg;
  assign forward_o = forward_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence write_pending;
    aw_got_reg && w_got_reg && !bvalid_reg;
  endsequence
  sequence write_answered;
    bvalid_reg && (bresp_reg == ($past(wr_ok) ? encoder_feedback_pkg::resp_okay :
                                                encoder_feedback_pkg::resp_slverr));
  endsequence

  a_ppr_reset: assert property ($past(sys_rst_i) |-> ppr_reg == `PPR_RESET)
    else $error("resolution not at power-on value");
  a_ppr_range: assert property (32'(ppr_reg) <= `PPR_MAX)
    else $error("resolution above limit");
  a_run_lock: assert property ($past(motor_running_i) |->
    $stable(ppr_reg) && $stable(pol_reg) && $stable(div_code_reg))
    else $error("setting changed while running");
  a_dir_pol0: assert property (a_rise && !pol_reg |=> forward_reg == $past(!b_level))
    else $error("wrong direction with polarity 0");
  a_dir_pol1: assert property (a_rise && pol_reg |=> forward_reg == $past(b_level))
    else $error("wrong direction with polarity 1");
  a_div_legal: assert property (div_legal({24'h0, div_code_reg}))
    else $error("illegal divider code held");
  a_monitor_cause: assert property (monitor_reg |-> $past(a_rise))
    else $error("monitor pulse without input pulse");
  a_acc_bound: assert property (acc_reg < div_m)
    else $error("accumulator out of range");
  a_sync_delay: assert property (a_rise |-> $past(phase_a_i, 2) && !$past(phase_a_i, 3))
    else $error("edge not two stages after pin");
  a_write_resp: assert property (write_pending |=> write_answered)
    else $error("write not answered correctly");

endmodule

//--- verification/quad_encoder_model.sv
`timescale 1ns/100ps
module quad_encoder_model #(parameter int qtr_cycles = 4) (
  output logic phase_a_o,
  output logic phase_b_o,
  output logic phase_z_o,
  input wire logic clk_i
);
  initial begin
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
    phase_z_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shaft stands still at 00 between calls, as a stopped encoder would
  task automatic spin(input int cycles, input bit a_lead);
    bit ld;
    bit lg;
    for (int i = 0; i < cycles; i++) begin
      for (int q = 0; q < 4; q++) begin
        repeat (qtr_cycles) @(posedge clk_i);
        ld = (q < 2);
        lg = (q == 1) || (q == 2);
        phase_a_o <= a_lead ? ld : lg;
        phase_b_o <= a_lead ? lg : ld;
        phase_z_o <= (i == 0) && (q == 0);
      end
    end
    repeat (qtr_cycles) @(posedge clk_i);
  endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/100ps
`include "encoder_feedback_map.svh"
module testbench;
  localparam logic [1:0] rsp_ok = encoder_feedback_pkg::resp_okay;
  localparam logic [1:0] rsp_err = encoder_feedback_pkg::resp_slverr;
  localparam logic [7:0] div_bad [4] = '{8'h00, 8'h21, 8'h64, 8'h85};
  localparam logic [7:0] div_code [5] = '{8'h01, 8'h02, 8'h20, 8'h84, 8'h65};
  localparam int div_rises [5] = '{3, 8, 64, 32, 5};
  localparam int div_exp [5] = '{3, 4, 2, 2, 5};
  // Position after two A rises with resolution 500, index first; order p0l0, p0l1, p1l0, p1l1
  localparam logic [31:0] pos_exp [4] = '{32'h000001f2, 32'h00000001, 32'h00000002,
                                          32'h000001f3};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic motor_running_i = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pulse_mon, fwd, pa, pb, pz;
  logic [1:0] bresp, rresp;
  int err_total = 0;
  int compares = 0;
  int pulse_cnt = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (pulse_mon === 1'b1) pulse_cnt++;
  quad_encoder_model #(.qtr_cycles(4)) enc (.clk_i(clk_i), .phase_a_o(pa), .phase_b_o(pb),
    .phase_z_o(pz));
  encoder_feedback_interface dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .phase_a_i(pa),
    .phase_b_i(pb), .phase_z_i(pz), .motor_running_i(motor_running_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pulse_monitor_o(pulse_mon),
    .forward_o(fwd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address and data are released independently, each on its own handshake
  task automatic wr(input logic [2:0] idx, input logic [31:0] d, input logic [1:0] exp);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_i);
    awaddr <= {27'h0, idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_i);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, exp});
  endtask
  task automatic rchk(input logic [2:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= {27'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, er});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    rchk(`IDX_PPR, 32'h000003e8, rsp_ok);
    rchk(`IDX_POL, 32'h0, rsp_ok);
    rchk(`IDX_DIV, 32'h1, rsp_ok);
    rchk(`IDX_STATUS, 32'h2, rsp_ok);
    rchk(3'h7, 32'h0, rsp_err);
    wr(`IDX_STATUS, 32'h0, rsp_err);
    $display("test_reset done");
  endtask
  task automatic test_ranges;
    wr(`IDX_PPR, 32'h0000ea60, rsp_ok);
    wr(`IDX_PPR, 32'h0000ea61, rsp_err);
    rchk(`IDX_PPR, 32'h0000ea60, rsp_ok);
    wr(`IDX_POL, 32'h2, rsp_err);
    for (int i = 0; i < 4; i++) wr(`IDX_DIV, {24'h0, div_bad[i]}, rsp_err);
    rchk(`IDX_DIV, 32'h1, rsp_ok);
    $display("test_ranges done");
  endtask
  task automatic test_lock;
    @(posedge clk_i);
    motor_running_i <= 1'b1;
    wr(`IDX_PPR, 32'h000001f4, rsp_err);
    wr(`IDX_POL, 32'h1, rsp_err);
    wr(`IDX_DIV, 32'h2, rsp_err);
    rchk(`IDX_STATUS, 32'h7, rsp_ok);
    rchk(`IDX_PPR, 32'h0000ea60, rsp_ok);
    motor_running_i <= 1'b0;
    wr(`IDX_PPR, 32'h000001f4, rsp_ok);
    rchk(`IDX_STATUS, 32'h2, rsp_ok);
    $display("test_lock done");
  endtask
  task automatic test_direction;
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        wr(`IDX_POL, 32'(p), rsp_ok);
        enc.spin(2, l[0]);
        check({31'h0, fwd}, {31'h0, l[0] ^ p[0]});
        rchk(`IDX_POS, pos_exp[p*2+l], rsp_ok);
      end
    end
    $display("test_direction done");
  endtask
  // Each accepted divider write clears the accumulator, so counts start clean
  task automatic test_divider;
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_DIV, {24'h0, div_code[i]}, rsp_ok);
      pulse_cnt = 0;
      enc.spin(div_rises[i], 1'b1);
      check(32'(pulse_cnt), 32'(div_exp[i]));
    end
    $display("test_divider done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    test_reset;
    test_ranges;
    test_lock;
    test_direction;
    test_divider;
    finish_test;
  end
  // Whole run needs about 2100 cycles; roughly ten times that means a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    finish_test;
  end
endmodule
